/* core/stl_pkg.sv */
package stl_pkg;

  // Register byte addresses (one aligned 32-bit word each)
  localparam logic [4:0] ADDR_CTRL     = 5'h00;
  localparam logic [4:0] ADDR_EMPH     = 5'h04;
  localparam logic [4:0] ADDR_POWER    = 5'h08;
  localparam logic [4:0] ADDR_BSCAN    = 5'h0C;
  localparam logic [4:0] ADDR_STATUS   = 5'h10;
  localparam logic [4:0] ADDR_INT_STAT = 5'h14;
  localparam logic [4:0] ADDR_INT_MASK = 5'h18;

  // Field positions
  localparam int REFSEL_LSB  = 0;
  localparam int LANE_OFF_B  = 0;
  localparam int GROUP_LSB   = 1;
  localparam int BS_EN_B     = 0;
  localparam int BS_VAL_B    = 1;
  localparam int ST_NOREF_B  = 0;
  localparam int ST_LOL_B    = 1;
  localparam int ST_LOLHI_B  = 2;
  localparam int ST_LOLLO_B  = 3;
  localparam int ST_BYPASS_B = 4;
  localparam int ST_DOWN_B   = 5;

  // Reset values
  localparam logic [1:0] REFSEL_RST = 2'h1;
  localparam logic [3:0] EMPH_RST   = 4'h0;

  // Reference ratio codes and divide factors
  localparam logic [1:0] REFSEL_DIV8  = 2'h0;
  localparam logic [1:0] REFSEL_DIV16 = 2'h1;
  localparam logic [1:0] REFSEL_DIV32 = 2'h2;
  localparam logic [5:0] DIV_8        = 6'h08;
  localparam logic [5:0] DIV_16       = 6'h10;
  localparam logic [5:0] DIV_32       = 6'h20;

  // Serialiser and detector figures
  localparam logic [2:0] BYTE_LAST   = 3'h7;
  localparam logic [2:0] BYTE_HALF   = 3'h4;
  localparam logic [2:0] NOREF_LIMIT = 3'h4;
  localparam logic [3:0] WIN_LAST    = 4'hF;
  localparam logic [5:0] WIN_EDGES   = 6'h10;
  localparam logic [5:0] LOCK_TOL    = 6'h02;

  // Lanes in the full device; each group size step halves the powered set
  localparam int LANE_TOTAL = 136;

  // Interrupt bit positions
  localparam int IRQ_NOREF = 0;
  localparam int IRQ_LOLHI = 1;
  localparam int IRQ_LOLLO = 2;
  localparam int IRQ_W     = 3;

  // Decoded driver settings
  typedef struct packed {
    logic [1:0] drive;    // 0 nominal, 1 mid, 2 high
    logic       emph_on;  // Pre-emphasis active
    logic [1:0] decay;    // 1 short, 2 long, 3 medium
    logic [1:0] level;    // 0 low .. 3 extra high
  } stl_drv_t;

endpackage : stl_pkg

/* core/stl_lane.sv */
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps

// Notes on behaviour
// - Take 8-bit words, multiply clock, serialise
// - Return byte-rate clock to core FIFO
// - Two-bit select: ratio 8, 16, 32
// - Faster divided clock high flag, slower low
// - Lock-loss equals OR of both flags
// - No reference toggle in four cycles: noref
// - Noref readable at general status bit zero
// - Byte-rate bus becomes one serial stream
// - Byte clock is bit clock over eight
// - Capture word on byte clock rising edge
// - Master reset asynchronously clears clock divider
// - Bypass high: bypass pin is bit clock
// - Four-bit code: drive bit over emphasis
// - Decode drive, decay and emphasis per table
// - Lane and lane-group power-down controls
// - Boundary scan forces the output pad
module stl_lane #(
  parameter int LANE_IDX = 0  // Position of this lane within the chip
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Core side
  input  wire logic [7:0]  tx_word,
  output logic             byte_clk_o,
  // Pins from outside the clock domain
  input  wire logic        tx_refclk_i,
  input  wire logic        bypass_clk_i,
  input  wire logic        pll_bypass_i,
  // Serial lane and driver controls
  output logic             tx_ser_o,
  output stl_pkg::stl_drv_t drv_o,
  output logic             lane_down_o,
  // Lock status and interrupt
  output logic             lolhi_o,
  output logic             lollo_o,
  output logic             lol_o,
  output logic             noref_o,
  output logic             irq_o
);

  // Complete state of the lane
  typedef struct packed {
    logic                  ack;      // Bus answer phase
    logic [31:0]           rdata;    // Read data
    logic [1:0]            refsel;   // Reference ratio select
    logic [3:0]            emph;     // Drive and emphasis code
    logic                  lane_off; // Own power-off
    logic [1:0]            group;    // Lane-group size
    logic                  bs_en;    // Pad force enable
    logic                  bs_val;   // Pad force value
    logic [stl_pkg::IRQ_W-1:0] ist;  // Sticky events
    logic [stl_pkg::IRQ_W-1:0] imsk; // Event mask
    logic [2:0]            ref_s;    // Reference synchroniser and history
    logic [2:0]            byp_s;    // Bypass clock synchroniser and history
    logic [1:0]            pb_s;     // Bypass select synchroniser
    logic [2:0]            div;      // Bit-to-byte divider
    logic [7:0]            shreg;    // Serialiser
    logic                  ser;      // Registered pad value
    logic [5:0]            dcnt;     // Feedback divider
    logic [3:0]            win;      // Lock window counter
    logic [5:0]            refcnt;   // Reference edges in window
    logic                  lolhi;
    logic                  lollo;
    logic [2:0]            nrcnt;    // Divided cycles since reference toggle
    logic                  noref;
    stl_pkg::stl_drv_t     drv;      // Decoded driver settings
  } stl_state_t;

  stl_state_t st_r;
  stl_state_t st_nxt;

  // Divide factor for the reference ratio
  function automatic logic [5:0] ratio_of(input logic [1:0] sel);
    if (sel == stl_pkg::REFSEL_DIV8) begin
      ratio_of = stl_pkg::DIV_8;
    end else if (sel == stl_pkg::REFSEL_DIV32) begin
      ratio_of = stl_pkg::DIV_32;
    end else begin
      ratio_of = stl_pkg::DIV_16;  // Code 3 falls back to the usual ratio
    end
  endfunction : ratio_of

  // Drive and emphasis table
  function automatic stl_pkg::stl_drv_t emph_decode(input logic [3:0] code);
    stl_pkg::stl_drv_t d;
    d = '0;
    if (code[3:2] == 2'h0) begin
      d.drive = (code[1:0] == 2'h3) ? 2'h2 : code[1:0];  // Codes 2 and 3 both high
    end else begin
      d.emph_on = 1'b1;
      d.decay   = code[3:2];
      d.level   = code[1:0];
    end
    emph_decode = d;
  endfunction : emph_decode

  // Lane sits in a powered-down set for the chosen group size
  function automatic logic group_down(input logic [1:0] g);
    if (g == 2'h0) begin
      group_down = 1'b0;
    end else begin
      group_down = (LANE_IDX >= (stl_pkg::LANE_TOTAL >> g));
    end
  endfunction : group_down

  // Combinational helpers
  logic       req;
  logic       down;
  logic       bypass;
  logic       bit_tick;
  logic       byte_tick;
  logic       dtick;
  logic       ref_tog;
  logic       ref_rise;
  logic [stl_pkg::IRQ_W-1:0] ev;
  logic       wr_ok;
  logic       rd_ok;

  // Next-state logic for the whole lane
  always_comb begin
    st_nxt   = st_r;
    req      = avs_read | avs_write;
    rd_ok    = avs_read & ~st_r.ack;
    wr_ok    = avs_write & st_r.ack;
    down     = st_r.lane_off | group_down(st_r.group);
    bypass   = st_r.pb_s[1];
    ref_tog  = st_r.ref_s[1] ^ st_r.ref_s[2];
    ref_rise = st_r.ref_s[1] & ~st_r.ref_s[2];
    ev       = '0;

    // Pin synchronisers, second stage feeds all logic
    st_nxt.ref_s = {st_r.ref_s[1:0], tx_refclk_i};
    st_nxt.byp_s = {st_r.byp_s[1:0], bypass_clk_i};
    st_nxt.pb_s  = {st_r.pb_s[0], pll_bypass_i};

    // Bit clock: multiplied clock, or bypass pin edges in test mode
    if (down) begin
      bit_tick = 1'b0;
    end else if (bypass) begin
      bit_tick = st_r.byp_s[1] & ~st_r.byp_s[2];
    end else begin
      bit_tick = 1'b1;
    end
    byte_tick = bit_tick & (st_r.div == stl_pkg::BYTE_LAST);

    // Divide by eight, load word on byte clock rise, shift MSB first
    if (bit_tick) begin
      st_nxt.div = st_r.div + 3'h1;
      if (byte_tick) begin
        st_nxt.shreg = tx_word;
      end else begin
        st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
      end
    end

    // Pad value, overridable by boundary scan
    if (st_r.bs_en) begin
      st_nxt.ser = st_r.bs_val;
    end else if (down) begin
      st_nxt.ser = 1'b0;
    end else if (bit_tick) begin
      st_nxt.ser = st_r.shreg[7];
    end

    // Feedback divider at the selected ratio
    dtick = 1'b0;
    if (bit_tick) begin
      if (st_r.dcnt >= ratio_of(st_r.refsel) - 6'h1) begin
        st_nxt.dcnt = '0;
        dtick       = 1'b1;
      end else begin
        st_nxt.dcnt = st_r.dcnt + 6'h1;
      end
    end

    // Loss of reference watchdog
    if (ref_tog) begin
      st_nxt.nrcnt = '0;
      st_nxt.noref = 1'b0;
    end else if (dtick && st_r.nrcnt != stl_pkg::NOREF_LIMIT) begin
      st_nxt.nrcnt = st_r.nrcnt + 3'h1;
      if (st_r.nrcnt == stl_pkg::NOREF_LIMIT - 3'h1) begin
        st_nxt.noref = 1'b1;
      end
    end

    // Frequency compare over a window of divided cycles
    if (ref_rise && st_r.refcnt != 6'h3F) begin
      st_nxt.refcnt = st_r.refcnt + 6'h1;
    end
    if (dtick) begin
      st_nxt.win = st_r.win + 4'h1;
      if (st_r.win == stl_pkg::WIN_LAST) begin
        // Fewer reference edges means the divided clock runs fast
        st_nxt.lolhi  = st_r.refcnt < stl_pkg::WIN_EDGES - stl_pkg::LOCK_TOL;
        st_nxt.lollo  = st_r.refcnt > stl_pkg::WIN_EDGES + stl_pkg::LOCK_TOL;
        st_nxt.refcnt = {5'h0, ref_rise};  // In-tolerance window clears both
      end
    end

    // Driver decode, registered
    st_nxt.drv = emph_decode(st_r.emph);

    // Bus answer one cycle after the request appears
    st_nxt.ack = req & ~st_r.ack;
    if (rd_ok) begin
      st_nxt.rdata = '0;
      if (avs_address == stl_pkg::ADDR_CTRL) begin
        st_nxt.rdata[stl_pkg::REFSEL_LSB +: 2] = st_r.refsel;
      end else if (avs_address == stl_pkg::ADDR_EMPH) begin
        st_nxt.rdata[3:0] = st_r.emph;
      end else if (avs_address == stl_pkg::ADDR_POWER) begin
        st_nxt.rdata[stl_pkg::LANE_OFF_B] = st_r.lane_off;
        st_nxt.rdata[stl_pkg::GROUP_LSB +: 2] = st_r.group;
      end else if (avs_address == stl_pkg::ADDR_BSCAN) begin
        st_nxt.rdata[stl_pkg::BS_EN_B]  = st_r.bs_en;
        st_nxt.rdata[stl_pkg::BS_VAL_B] = st_r.bs_val;
      end else if (avs_address == stl_pkg::ADDR_STATUS) begin
        st_nxt.rdata[stl_pkg::ST_NOREF_B]  = st_r.noref;
        st_nxt.rdata[stl_pkg::ST_LOL_B]    = st_r.lolhi | st_r.lollo;
        st_nxt.rdata[stl_pkg::ST_LOLHI_B]  = st_r.lolhi;
        st_nxt.rdata[stl_pkg::ST_LOLLO_B]  = st_r.lollo;
        st_nxt.rdata[stl_pkg::ST_BYPASS_B] = bypass;
        st_nxt.rdata[stl_pkg::ST_DOWN_B]   = down;
      end else if (avs_address == stl_pkg::ADDR_INT_STAT) begin
        st_nxt.rdata[stl_pkg::IRQ_W-1:0] = st_r.ist;
      end else if (avs_address == stl_pkg::ADDR_INT_MASK) begin
        st_nxt.rdata[stl_pkg::IRQ_W-1:0] = st_r.imsk;
      end
    end

    // Register writes land on the answering edge
    if (wr_ok) begin
      if (avs_address == stl_pkg::ADDR_CTRL) begin
        st_nxt.refsel = avs_writedata[stl_pkg::REFSEL_LSB +: 2];
      end else if (avs_address == stl_pkg::ADDR_EMPH) begin
        st_nxt.emph = avs_writedata[3:0];
      end else if (avs_address == stl_pkg::ADDR_POWER) begin
        st_nxt.lane_off = avs_writedata[stl_pkg::LANE_OFF_B];
        st_nxt.group    = avs_writedata[stl_pkg::GROUP_LSB +: 2];
      end else if (avs_address == stl_pkg::ADDR_BSCAN) begin
        st_nxt.bs_en  = avs_writedata[stl_pkg::BS_EN_B];
        st_nxt.bs_val = avs_writedata[stl_pkg::BS_VAL_B];
      end else if (avs_address == stl_pkg::ADDR_INT_STAT) begin
        st_nxt.ist = st_r.ist & ~avs_writedata[stl_pkg::IRQ_W-1:0];
      end else if (avs_address == stl_pkg::ADDR_INT_MASK) begin
        st_nxt.imsk = avs_writedata[stl_pkg::IRQ_W-1:0];
      end
    end

    // Events set after the clear so a same-cycle event is kept
    ev[stl_pkg::IRQ_NOREF] = st_nxt.noref & ~st_r.noref;
    ev[stl_pkg::IRQ_LOLHI] = st_nxt.lolhi & ~st_r.lolhi;
    ev[stl_pkg::IRQ_LOLLO] = st_nxt.lollo & ~st_r.lollo;
    st_nxt.ist = st_nxt.ist | ev;
  end

  // State register; master reset also fixes the divider phase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r        <= '0;
      st_r.refsel <= stl_pkg::REFSEL_RST;
      st_r.emph   <= stl_pkg::EMPH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs from state; waitrequest also takes the bus strobes
  assign avs_waitrequest = req & ~st_r.ack;
  assign avs_readdata    = st_r.rdata;
  assign byte_clk_o      = (st_r.div < stl_pkg::BYTE_HALF);
  assign tx_ser_o        = st_r.ser;
  assign drv_o           = st_r.drv;
  assign lane_down_o     = down;
  assign lolhi_o         = st_r.lolhi;
  assign lollo_o         = st_r.lollo;
  assign lol_o           = st_r.lolhi | st_r.lollo;
  assign noref_o         = st_r.noref;
  assign irq_o           = |(st_r.ist & st_r.imsk);

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic run_free;
  assign run_free = ~down & ~bypass;

  // Combined flag must track both sides at all times
  a_lol_or_flags: assert property (lol_o == (lolhi_o | lollo_o))
    else $error("lock-loss is not the OR of its flags");

  // A window is either fast or slow, never both
  a_lock_flags_excl: assert property (!(lolhi_o && lollo_o))
    else $error("both lock-loss flags set");

  // Window end inside tolerance leaves both flags low
  a_in_tol_clear: assert property (
    (dtick && st_r.win == stl_pkg::WIN_LAST
      && st_r.refcnt >= stl_pkg::WIN_EDGES - stl_pkg::LOCK_TOL
      && st_r.refcnt <= stl_pkg::WIN_EDGES + stl_pkg::LOCK_TOL) |=> !lol_o)
    else $error("lock-loss flag set inside tolerance");

  // Eight free-running ticks bring the next rise, one cycle after the last
  a_byte_div_eight: assert property (
    ($rose(byte_clk_o) && run_free) ##1 run_free [*7] |=> $rose(byte_clk_o))
    else $error("byte clock period is not eight bit clocks");

  // Word must sit in the serialiser as the byte clock rises
  a_word_capture: assert property (
    $rose(byte_clk_o) |-> st_r.shreg == $past(tx_word))
    else $error("word not captured at byte clock rise");

  // Pad follows the serialiser head on every tick
  a_serial_msb: assert property (
    (run_free && !st_r.bs_en) |=> tx_ser_o == $past(st_r.shreg[7]))
    else $error("serial bit not taken from serialiser head");

  // Watchdog fires exactly on the fourth silent tick
  a_noref_count: assert property (
    $rose(noref_o) |-> $past(st_r.nrcnt) == stl_pkg::NOREF_LIMIT - 3'h1)
    else $error("noref declared at wrong count");

  // Sticky bit set on the same edge, even against a clear
  a_noref_sticky: assert property (
    $rose(noref_o) |-> st_r.ist[stl_pkg::IRQ_NOREF])
    else $error("noref event not latched");

  // Status read returns the live noref level
  a_status_noref: assert property (
    (avs_read && !st_r.ack && avs_address == stl_pkg::ADDR_STATUS)
      |=> avs_readdata[stl_pkg::ST_NOREF_B] == $past(noref_o))
    else $error("status bit zero does not show noref");

  // Decode registered one cycle behind the code
  a_emph_decode: assert property (1'b1 |=> drv_o == emph_decode($past(st_r.emph)))
    else $error("driver settings differ from code");

  // Divider frozen while powered down
  a_power_down: assert property (down |=> $stable(byte_clk_o))
    else $error("byte clock runs while lane powered down");

  // Powered-down pad rests low unless scan forces it
  a_down_pad: assert property ((down && !st_r.bs_en) |=> !tx_ser_o)
    else $error("powered-down pad not low");

  // In bypass the divider moves only on bypass clock edges
  a_bypass_hold: assert property (
    (bypass && !(st_r.byp_s[1] && !st_r.byp_s[2])) |=> $stable(st_r.div))
    else $error("divider moved without a bypass clock edge");

  // Scan force overrides everything on the next edge
  a_bscan_force: assert property (st_r.bs_en |=> tx_ser_o == $past(st_r.bs_val))
    else $error("boundary scan did not force the pad");

  // Main scenarios that the bench should reach
  c_noref_seen:  cover property ($rose(noref_o));
  c_lol_seen:    cover property ($rose(lol_o));
  c_byte_run:    cover property ($rose(byte_clk_o) && run_free);
  c_bus_write:   cover property (avs_write && !avs_waitrequest);
  c_bypass_tick: cover property (bypass && bit_tick);

endmodule : stl_lane

/* bench/stl_far_end.sv */
`timescale 1ns/10ps

// Far side: reference oscillator and serial receiver of the lane
module stl_far_end (
  // Clock and controls from the bench
  input  wire logic       ref_clk,
  input  wire logic       ref_en,
  input  wire logic [7:0] ref_half,
  // Lane outputs watched
  input  wire logic       tx_ser_o,
  input  wire logic       byte_clk_o,
  // Reference pin and recovered words
  output logic            tx_refclk_i,
  output logic      [7:0] rx_word,
  output logic            rx_stb
);
  logic [7:0] sh_r;  // Last serial samples
  logic       bc_q;  // Byte clock one cycle late

  // Free oscillator, odd offset so it never lines up with the system clock
  initial begin
    tx_refclk_i = 1'b0;
    #1.3;
    forever begin
      #(ref_half);
      // Stopped oscillator holds its level, so loss of reference can be seen
      if (ref_en) tx_refclk_i = ~tx_refclk_i;
    end
  end

  // Receiver: word framed on each byte clock rise, first bit is the MSB
  always_ff @(posedge ref_clk) begin
    sh_r    <= {sh_r[6:0], tx_ser_o};
    bc_q    <= byte_clk_o;
    rx_stb  <= byte_clk_o & ~bc_q;
    rx_word <= {sh_r[6:0], tx_ser_o};
  end
endmodule : stl_far_end

/* bench/stl_lane_tb_top.sv */
`timescale 1ns/10ps

// Register-level bench for one transmit lane
module stl_lane_tb_top;
  logic              ref_clk, sys_rst;           // Clock and reset
  logic [4:0]        avs_address;                // Bus address
  logic              avs_read, avs_write;        // Bus strobes
  logic [31:0]       avs_writedata, avs_readdata; // Bus data
  logic              avs_waitrequest;            // Bus stall
  logic [7:0]        tx_word, rx_word, prev_word; // Stream words
  logic              byte_clk_o, bc_q;           // Byte clock and delayed copy
  logic              tx_refclk_i, ref_en;        // Reference pin and run flag
  logic [7:0]        ref_half;                   // Reference half period in ns
  logic              bypass_clk_i, pll_bypass_i; // Bypass pins
  logic              byp_run;                    // Bypass clock running
  logic [2:0]        byp_cnt;                    // Bypass clock divider
  logic              tx_ser_o, rx_stb;           // Serial pad and word strobe
  stl_pkg::stl_drv_t drv_o;                      // Driver settings
  logic              lane_down_o, lolhi_o, lollo_o, lol_o, noref_o, irq_o;
  logic              ser_chk, have_prev;         // Stream check state
  logic [31:0]       rd;                         // Last read value
  int                err_total, checks, cyc;     // Counters
  // Lock table: ratio code, reference half period, expected status nibble
  logic [1:0] sel_t [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h1, 2'h1};
  logic [7:0] ht_t  [7] = '{8'h14, 8'h28, 8'h50, 8'h28, 8'h14, 8'h50, 8'h28};
  logic [3:0] nib_t [7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hA, 4'h6, 4'h0};
  // Power table: register value and expected power-down for lane 40
  logic [2:0] pw_t  [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
  logic       pd_t  [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  stl_lane #(.LANE_IDX(40)) i_stl_lane (
    .ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .tx_word, .byte_clk_o, .tx_refclk_i,
    .bypass_clk_i, .pll_bypass_i, .tx_ser_o, .drv_o, .lane_down_o, .lolhi_o,
    .lollo_o, .lol_o, .noref_o, .irq_o
  );
  stl_far_end i_stl_far_end (
    .ref_clk, .ref_en, .ref_half, .tx_ser_o, .byte_clk_o, .tx_refclk_i, .rx_word, .rx_stb
  );

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One bus transfer, held until the edge with waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge ref_clk);
    // Only the hang guard ends a wait that never answers
    while (avs_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Read and compare
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk

  // Count byte clock transitions over n cycles
  task automatic count_bc(input int n, output int k);
    logic p;
    k = 0;
    p = byte_clk_o;
    repeat (n) begin
      @(negedge ref_clk);
      if (byte_clk_o !== p) k++;
      p = byte_clk_o;
    end
  endtask : count_bc

  // Closing report
  task automatic give_verdict();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // Core FIFO model: next word on each byte clock rise, stream checked at far side
  always @(posedge ref_clk) begin
    cyc  <= cyc + 1;
    bc_q <= byte_clk_o;
    if (byte_clk_o && !bc_q) tx_word <= tx_word + 8'h3B;
    if (rx_stb === 1'b1 && ser_chk) begin
      if (have_prev) chk({24'h0, rx_word}, {24'h0, prev_word + 8'h3B});
      prev_word <= rx_word;
      have_prev <= 1'b1;
    end
    if (!ser_chk) have_prev <= 1'b0;
    // Hang guard
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  // Slow bypass bit clock, period twelve system cycles
  always @(posedge ref_clk) begin
    if (byp_run) begin
      byp_cnt <= (byp_cnt == 3'h5) ? 3'h0 : byp_cnt + 3'h1;
      if (byp_cnt == 3'h5) bypass_clk_i <= ~bypass_clk_i;
    end
  end

  // Main sequence
  initial begin
    int k;
    logic [3:0] cv;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {tx_word, pll_bypass_i, bypass_clk_i, byp_run, byp_cnt, ser_chk, have_prev} = '0;
    {prev_word, err_total, checks, cyc, k, cv} = '0;
    sys_rst = 1'b1;
    ref_en = 1'b1;
    ref_half = 8'h28;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rchk(stl_pkg::ADDR_CTRL, 32'h1);
    rchk(stl_pkg::ADDR_EMPH, 32'h0);
    rchk(stl_pkg::ADDR_POWER, 32'h0);
    rchk(stl_pkg::ADDR_BSCAN, 32'h0);
    rchk(stl_pkg::ADDR_INT_MASK, 32'h0);
    bus(1'b1, 5'h1C, 32'hFFFFFFFF);
    rchk(5'h1C, 32'h0);
    ser_chk <= 1'b1;
    // Ratio select and lock flags over matched and mismatched references
    for (int i = 0; i < 7; i++) begin
      int rr;
      rr = (sel_t[i] == 2'h0) ? 8 : (sel_t[i] == 2'h2) ? 32 : 16;
      ref_half <= ht_t[i];
      bus(1'b1, stl_pkg::ADDR_CTRL, {30'h0, sel_t[i]});
      repeat (48 * rr) @(posedge ref_clk);
      rchk(stl_pkg::ADDR_STATUS, {28'h0, nib_t[i]});
      chk({lollo_o, lolhi_o, lol_o, noref_o}, nib_t[i]);
    end
    rchk(stl_pkg::ADDR_INT_STAT, 32'h6);
    chk(irq_o, 1'b0);
    bus(1'b1, stl_pkg::ADDR_INT_MASK, 32'h4);
    @(negedge ref_clk);
    chk(irq_o, 1'b1);
    bus(1'b1, stl_pkg::ADDR_INT_STAT, 32'h6);
    rchk(stl_pkg::ADDR_INT_STAT, 32'h0);
    chk(irq_o, 1'b0);
    // Reference stops, then restarts
    ref_en <= 1'b0;
    repeat (30) @(posedge ref_clk);
    chk(noref_o, 1'b0);
    repeat (70) @(posedge ref_clk);
    chk(noref_o, 1'b1);
    bus(1'b0, stl_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    bus(1'b1, stl_pkg::ADDR_INT_MASK, 32'h1);
    @(negedge ref_clk);
    chk(irq_o, 1'b1);
    ref_en <= 1'b1;
    repeat (768) @(posedge ref_clk);
    chk(noref_o, 1'b0);
    bus(1'b1, stl_pkg::ADDR_INT_STAT, 32'h7);
    rchk(stl_pkg::ADDR_STATUS, 32'h0);
    chk(irq_o, 1'b0);
    // Every drive and emphasis code
    for (int c = 0; c < 16; c++) begin
      cv = 4'(c);
      bus(1'b1, stl_pkg::ADDR_EMPH, {28'h0, cv});
      rchk(stl_pkg::ADDR_EMPH, {28'h0, cv});
      if (c < 4) chk({drv_o.drive, drv_o.emph_on}, {2'(c > 1 ? 2 : c), 1'b0});
      else chk({drv_o.emph_on, drv_o.decay, drv_o.level}, {1'b1, cv});
    end
    ser_chk <= 1'b0;
    // Lane and group power-down
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, stl_pkg::ADDR_POWER, {29'h0, pw_t[i]});
      repeat (10) @(posedge ref_clk);
      chk(lane_down_o, pd_t[i]);
      if (pd_t[i]) chk(tx_ser_o, 1'b0);
      bus(1'b0, stl_pkg::ADDR_STATUS, 32'h0);
      chk(rd & 32'h20, {26'h0, pd_t[i], 5'h0});
    end
    // Pad forcing, lane down then up
    bus(1'b1, stl_pkg::ADDR_BSCAN, 32'h3);
    repeat (2) @(negedge ref_clk);
    chk(tx_ser_o, 1'b1);
    bus(1'b1, stl_pkg::ADDR_POWER, 32'h0);
    repeat (16) begin
      @(negedge ref_clk);
      chk(tx_ser_o, 1'b1);
    end
    bus(1'b1, stl_pkg::ADDR_BSCAN, 32'h1);
    repeat (2) @(negedge ref_clk);
    chk(tx_ser_o, 1'b0);
    bus(1'b1, stl_pkg::ADDR_BSCAN, 32'h0);
    // Bypass: no ticks without the bypass clock, ticks follow it
    pll_bypass_i <= 1'b1;
    repeat (10) @(posedge ref_clk);
    bus(1'b0, stl_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h10, 32'h10);
    count_bc(64, k);
    chk(k, 0);
    byp_run <= 1'b1;
    count_bc(192, k);
    chk(k >= 3 && k <= 5, 1'b1);
    pll_bypass_i <= 1'b0;
    byp_run <= 1'b0;
    // Reset in mid-run forces divider and registers at once
    bus(1'b1, stl_pkg::ADDR_CTRL, 32'h2);
    sys_rst <= 1'b1;
    @(negedge ref_clk);
    chk({byte_clk_o, tx_ser_o}, 2'h2);
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rchk(stl_pkg::ADDR_CTRL, 32'h1);
    give_verdict();
  end
endmodule : stl_lane_tb_top
